// ---- rtl/slot_hotplug_pkg.sv ----
package slot_hotplug_pkg;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_KHZ           = 125000;
    localparam int ILK_PULSE_MS      = 125;
    localparam int ILK_PULSE_CYC     = ILK_PULSE_MS * CLK_KHZ;
    localparam int MS_CYC            = CLK_KHZ;
    localparam int ILK_CNT_W         = 24;
    localparam int MS_CNT_W          = 17;

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_SLOT_CAP = 8'h00;
    localparam logic [7:0] OFS_HP_CFG   = 8'h04;
    localparam logic [7:0] OFS_SLOT_CTL = 8'h08;
    localparam logic [7:0] OFS_SLOT_STS = 8'h0C;
    localparam logic [7:0] OFS_PM_CTL   = 8'h10;
    localparam logic [7:0] OFS_GE_STS   = 8'h14;

    // ---------------------------------------------------------------
    // Slot inputs and event bits
    // ---------------------------------------------------------------
    localparam int IN_BTN  = 0;
    localparam int IN_FLT  = 1;
    localparam int IN_LAT  = 2;
    localparam int IN_PRS  = 3;
    localparam int IN_PGD  = 4;
    localparam int NUM_IN  = 5;
    localparam int NUM_EV  = 5;
    localparam int EV_CC   = 4;

    // Slot capabilities
    localparam int CAP_HPC  = 0;
    localparam int CAP_LATCH_PRESENT_BIT = 1;

    // Hot-plug configuration: bits 0..4 input polarity, 5..8 output polarity
    localparam int CFG_POL_OUT  = 5;
    localparam int OUT_ATTN     = 0;
    localparam int OUT_PIND     = 1;
    localparam int OUT_PEN      = 2;
    localparam int OUT_ILK      = 3;
    localparam int NUM_OUT      = 4;
    localparam int CFG_TOGGLE   = 9;
    localparam int CFG_LAT_ILK  = 10;
    localparam int CFG_AUTO_OFF = 11;
    localparam int CFG_W        = 12;

    // Slot control: bits 0..4 event masks
    localparam int CTL_IRQ_ON   = 5;
    localparam int CTL_ATTN     = 6;
    localparam int CTL_PIND     = 7;
    localparam int CTL_PWR_OFF  = 8;
    localparam int CTL_ILK_CMD  = 9;
    localparam int CTL_W        = 9;

    // Slot status: bits 0..4 flags
    localparam int STS_LAT_ST   = 5;
    localparam int STS_PRS_ST   = 6;
    localparam int STS_ILK_ST   = 7;
    localparam int STS_PGD_ST   = 8;

    // Power management / event routing
    localparam int PM_MSI_EN    = 0;
    localparam int PM_INTX_DIS  = 1;
    localparam int PM_D3_PORT   = 2;
    localparam int PM_D3_SWITCH = 3;
    localparam int PM_GE_CTL    = 4;
    localparam int PM_GPIO_ALT  = 5;
    localparam int PM_W         = 6;
    localparam int PM_WAKE_STS  = 8;
    localparam int PM_TO_LSB    = 16;
    localparam int PM_TO_W      = 16;

    localparam logic [PM_TO_W-1:0] PME_TO_RESET = 16'h0064;
    localparam logic [CFG_W-1:0]   CFG_RESET    = 12'h000;
    localparam logic [CTL_W-1:0]   CTL_RESET    = 9'h11F;

    typedef enum logic [1:0] {BUS_IDLE, BUS_RD_WAIT} bus_state_e;

endpackage : slot_hotplug_pkg

// ---- rtl/downstream_slot_hotplug_ctrl.sv ----
`timescale 1ns/10ps
module downstream_slot_hotplug_ctrl
    import slot_hotplug_pkg::*;
#(
    parameter int ILK_CYCLES = ILK_PULSE_CYC,
    parameter int MS_CYCLES  = MS_CYC
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        attention_button_in,
    input  wire logic        presence_detect_in,
    input  wire logic        power_fault_in,
    input  wire logic        retention_latch_in,
    input  wire logic        slot_power_good_in,
    output logic             attention_indicator_out,
    output logic             power_indicator_out,
    output logic             slot_power_enable_out,
    output logic             interlock_out,
    output logic             intx_assert,
    output logic             msi_req,
    output logic             pme_msg_req,
    output logic             general_event_out,
    output logic             gpio7_out
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [NUM_IN-1:0]    sync1;
        logic [NUM_IN-1:0]    sync2;
        logic [NUM_IN-1:0]    prev;
        logic                 primed;
        logic [1:0]           cap;
        logic [CFG_W-1:0]     cfg;
        logic [CTL_W-1:0]     ctl;
        logic [NUM_EV-1:0]    flags;
        logic [PM_W-1:0]      pm;
        logic [PM_TO_W-1:0]   pme_to;
        logic                 wake_sts;
        logic                 ge_sts;
        logic                 ilk;
        logic [ILK_CNT_W-1:0] ilk_cnt;
        logic [MS_CNT_W-1:0]  ms_cnt;
        logic [PM_TO_W-1:0]   pme_ms;
        bus_state_e           bus;
        logic                 wr_pend;
        logic [7:0]           addr_q;
        logic                 hready_o;
        logic [31:0]          rdata;
        logic [NUM_OUT-1:0]   slot_o;
        logic                 intx_o;
        logic                 msi_o;
        logic                 pme_o;
        logic                 ge_o;
        logic                 gpio_o;
    } state_s;

    state_s state_reg;
    state_s state_next;
    logic   rst_meta;
    logic   rst_n_s;

    // Full count loaded, so the interlock stays asserted for exactly ILK_CYCLES edges
    localparam logic [ILK_CNT_W-1:0] ILK_LOAD = ILK_CNT_W'(ILK_CYCLES);
    localparam logic [MS_CNT_W-1:0]  MS_LOAD  = MS_CNT_W'(MS_CYCLES - 1);

    // ---------------------------------------------------------------
    // Reset release
    // ---------------------------------------------------------------
    // Two flops, so every register leaves reset on the same edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n_s  <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n_s  <= rst_meta;
        end
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        // ------------------------
        // Working values
        // ------------------------
        logic [NUM_IN-1:0] cur;
        logic [NUM_EV-1:0] ev;
        logic [NUM_EV-1:0] unmasked;
        logic [NUM_EV-1:0] clr;
        logic [NUM_OUT-1:0] lvl;
        logic [31:0]       rd;
        logic              enabled;
        logic              d3;
        logic              ge_mode;
        logic              any_new;
        logic              wake_new;
        logic              ilk_cmd;
        logic              ge_clr;
        logic              wake_clr;
        logic              pme_retry;
        logic              latch_open;
        logic              take;
        // ------------------------
        // Defaults
        // ------------------------
        cur        = '0;
        ev         = '0;
        unmasked   = '0;
        clr        = '0;
        lvl        = '0;
        rd         = '0;
        enabled    = 1'b0;
        d3         = 1'b0;
        ge_mode    = 1'b0;
        any_new    = 1'b0;
        wake_new   = 1'b0;
        ilk_cmd    = 1'b0;
        ge_clr     = 1'b0;
        wake_clr   = 1'b0;
        pme_retry  = 1'b0;
        latch_open = 1'b0;
        take       = 1'b0;
        state_next = state_reg;

        // ------------------------
        // Two-stage capture of expander inputs
        // ------------------------
        state_next.sync1 = {slot_power_good_in, presence_detect_in, retention_latch_in,
                            power_fault_in, attention_button_in};
        state_next.sync2 = state_reg.sync1;
        cur = state_reg.sync2 ^ state_reg.cfg[NUM_IN-1:0];
        state_next.prev   = cur;
        state_next.primed = 1'b1;

        enabled = state_reg.cap[CAP_HPC];
        ge_mode = state_reg.pm[PM_GE_CTL];
        d3      = state_reg.pm[PM_D3_PORT] | state_reg.pm[PM_D3_SWITCH];
        latch_open = cur[IN_LAT];

        // ------------------------
        // Input events; first sample after reset only primes the history
        // ------------------------
        // Changing polarity while capable looks like an input edge
        if (enabled && state_reg.primed) begin
            ev[IN_BTN] = cur[IN_BTN] & ~state_reg.prev[IN_BTN];
            ev[IN_FLT] = cur[IN_FLT] & ~state_reg.prev[IN_FLT];
            ev[IN_LAT] = cur[IN_LAT] ^ state_reg.prev[IN_LAT];
            ev[IN_PRS] = cur[IN_PRS] ^ state_reg.prev[IN_PRS];
        end

        // ------------------------
        // Bus: write data phase
        // ------------------------
        if (state_reg.wr_pend) begin
            if (state_reg.addr_q == OFS_SLOT_CAP) begin
                state_next.cap = hwdata[1:0];
            end else if (state_reg.addr_q == OFS_HP_CFG) begin
                state_next.cfg = hwdata[CFG_W-1:0];
            end else if (state_reg.addr_q == OFS_SLOT_CTL) begin
                state_next.ctl = hwdata[CTL_W-1:0];
                ilk_cmd = hwdata[CTL_ILK_CMD] & enabled;
                ev[EV_CC] = enabled;
            end else if (state_reg.addr_q == OFS_SLOT_STS) begin
                clr = hwdata[NUM_EV-1:0];
            end else if (state_reg.addr_q == OFS_PM_CTL) begin
                state_next.pm     = hwdata[PM_W-1:0];
                state_next.pme_to = hwdata[PM_TO_LSB +: PM_TO_W];
                wake_clr = hwdata[PM_WAKE_STS];
            end else if (state_reg.addr_q == OFS_GE_STS) begin
                ge_clr = hwdata[0];
            end
        end

        // ------------------------
        // Flags: a new event wins over a clear in the same cycle
        // ------------------------
        state_next.flags = (state_reg.flags & ~clr) | ev;
        // Masks and enable as just written, so a command that disables interrupts raises none
        unmasked = ev & ~state_next.ctl[NUM_EV-1:0];
        any_new  = |unmasked;
        wake_new = (|unmasked[NUM_EV-2:0]) & d3 & ~ge_mode;

        // ------------------------
        // General event routing
        // ------------------------
        state_next.ge_sts = (state_reg.ge_sts & ~ge_clr) | (any_new & ge_mode);
        state_next.ge_o   = state_next.ge_sts;
        state_next.gpio_o = state_next.ge_sts & state_reg.pm[PM_GPIO_ALT];

        // ------------------------
        // Interrupt delivery
        // ------------------------
        state_next.msi_o  = any_new & ~ge_mode & state_next.ctl[CTL_IRQ_ON]
                            & state_reg.pm[PM_MSI_EN];
        state_next.intx_o = (|(state_next.flags & ~state_next.ctl[NUM_EV-1:0]))
                            & state_next.ctl[CTL_IRQ_ON] & ~state_next.pm[PM_GE_CTL]
                            & ~state_next.pm[PM_MSI_EN] & ~state_next.pm[PM_INTX_DIS];

        // ------------------------
        // Wake messages with resend timer
        // ------------------------
        state_next.pme_o = 1'b0;
        if (state_reg.ms_cnt == '0) begin
            state_next.ms_cnt = MS_LOAD;
        end else begin
            state_next.ms_cnt = state_reg.ms_cnt - 1'b1;
        end
        if (state_reg.wake_sts && state_reg.ms_cnt == '0) begin
            if (state_reg.pme_ms <= 16'h0001) begin
                // A resend is a wake message too, so general-event mode blocks it
                pme_retry = (state_reg.pme_to != '0) & ~ge_mode;
            end else begin
                state_next.pme_ms = state_reg.pme_ms - 1'b1;
            end
        end
        if (wake_new || pme_retry) begin
            state_next.pme_o  = 1'b1;
            state_next.pme_ms = state_reg.pme_to;
            state_next.ms_cnt = MS_LOAD;
        end
        state_next.wake_sts = (state_reg.wake_sts & ~wake_clr) | wake_new;

        // ------------------------
        // Interlock: timed pulse or toggle
        // ------------------------
        if (state_reg.ilk_cnt != '0) begin
            state_next.ilk_cnt = state_reg.ilk_cnt - 1'b1;
            if (state_reg.ilk_cnt == 24'h000001) begin
                state_next.ilk = 1'b0;
            end
        end
        if (ilk_cmd) begin
            if (state_reg.cfg[CFG_TOGGLE]) begin
                state_next.ilk     = ~state_reg.ilk;
                state_next.ilk_cnt = '0;
            end else if (!state_reg.ilk) begin
                state_next.ilk     = 1'b1;
                state_next.ilk_cnt = ILK_LOAD;
            end
        end

        // ------------------------
        // Slot outputs, logical level then polarity
        // ------------------------
        lvl[OUT_ATTN] = enabled & state_reg.ctl[CTL_ATTN];
        lvl[OUT_PIND] = enabled & state_reg.ctl[CTL_PIND];
        lvl[OUT_PEN]  = enabled & ~state_reg.ctl[CTL_PWR_OFF]
                        & ~(state_reg.cfg[CFG_AUTO_OFF] & state_reg.cap[CAP_LATCH_PRESENT_BIT] & latch_open);
        lvl[OUT_ILK]  = enabled & state_reg.ilk;
        state_next.slot_o = lvl ^ state_reg.cfg[CFG_POL_OUT +: NUM_OUT];

        // ------------------------
        // Read mux
        // ------------------------
        if (state_reg.addr_q == OFS_SLOT_CAP) begin
            rd[1:0] = state_reg.cap;
        end else if (state_reg.addr_q == OFS_HP_CFG) begin
            rd[CFG_W-1:0] = state_reg.cfg;
        end else if (state_reg.addr_q == OFS_SLOT_CTL) begin
            rd[CTL_W-1:0] = state_reg.ctl;
        end else if (state_reg.addr_q == OFS_SLOT_STS) begin
            rd[NUM_EV-1:0] = state_reg.flags;
            rd[STS_LAT_ST] = state_reg.cfg[CFG_LAT_ILK] ? 1'b0 : cur[IN_LAT];
            rd[STS_PRS_ST] = cur[IN_PRS];
            rd[STS_ILK_ST] = state_reg.cfg[CFG_LAT_ILK] ? cur[IN_LAT]
                                                        : state_reg.slot_o[OUT_ILK];
            rd[STS_PGD_ST] = cur[IN_PGD];
        end else if (state_reg.addr_q == OFS_PM_CTL) begin
            rd[PM_W-1:0]              = state_reg.pm;
            rd[PM_WAKE_STS]           = state_reg.wake_sts;
            rd[PM_TO_LSB +: PM_TO_W]  = state_reg.pme_to;
        end else if (state_reg.addr_q == OFS_GE_STS) begin
            rd[0] = state_reg.ge_sts;
        end

        // ------------------------
        // AHB-Lite slave: writes zero-wait, reads one wait state
        // ------------------------
        take = hsel & htrans[1] & hready;
        state_next.wr_pend = 1'b0;
        case (state_reg.bus)
            BUS_IDLE: begin
                state_next.hready_o = 1'b1;
                if (take) begin
                    state_next.addr_q = {haddr[7:2], 2'b00};
                    if (hwrite) begin
                        state_next.wr_pend = 1'b1;
                    end else begin
                        state_next.bus      = BUS_RD_WAIT;
                        state_next.hready_o = 1'b0;
                    end
                end
            end
            BUS_RD_WAIT: begin
                state_next.rdata    = rd;
                state_next.hready_o = 1'b1;
                state_next.bus      = BUS_IDLE;
            end
            default: begin
                state_next.bus = BUS_IDLE;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            state_reg          <= '0;
            state_reg.cfg      <= CFG_RESET;
            state_reg.ctl      <= CTL_RESET;
            state_reg.pme_to   <= PME_TO_RESET;
            state_reg.hready_o <= 1'b1;
            state_reg.bus      <= BUS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign hreadyout               = state_reg.hready_o;
    assign hrdata                  = state_reg.rdata;
    assign hresp                   = 1'b0;
    assign attention_indicator_out = state_reg.slot_o[OUT_ATTN];
    assign power_indicator_out     = state_reg.slot_o[OUT_PIND];
    assign slot_power_enable_out   = state_reg.slot_o[OUT_PEN];
    assign interlock_out           = state_reg.slot_o[OUT_ILK];
    assign intx_assert             = state_reg.intx_o;
    assign msi_req                 = state_reg.msi_o;
    assign pme_msg_req             = state_reg.pme_o;
    assign general_event_out       = state_reg.ge_o;
    assign gpio7_out               = state_reg.gpio_o;

endmodule : downstream_slot_hotplug_ctrl

// ---- testbench/slot_hotplug_asserts.sv ----
`timescale 1ns/10ps
module slot_hotplug_asserts
    import slot_hotplug_pkg::*;
#(
    parameter int ILK_CYCLES = ILK_PULSE_CYC
) (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic        attention_indicator_out,
    input wire logic        slot_power_enable_out,
    input wire logic        interlock_out,
    input wire logic        intx_assert,
    input wire logic        msi_req,
    input wire logic        pme_msg_req,
    input wire logic        general_event_out,
    input wire logic        gpio7_out
);
    // ----------------------------------------
    // Register shadows from observed writes
    // ----------------------------------------
    logic        wv_reg;
    logic [7:0]  wa_reg;
    logic [31:0] cap_reg, cfg_reg, ctl_reg, pm_reg;
    int          ilk_reg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wv_reg  <= 1'b0;
            wa_reg  <= 8'h00;
            cap_reg <= 32'h0;
            cfg_reg <= 32'h0;
            ctl_reg <= 32'h11F;
            pm_reg  <= 32'h0;
            ilk_reg <= 0;
        end else begin
            wv_reg  <= hsel && htrans[1] && hwrite && hready;
            wa_reg  <= haddr[7:0];
            if (wv_reg && wa_reg == OFS_SLOT_CAP) cap_reg <= hwdata;
            if (wv_reg && wa_reg == OFS_HP_CFG) cfg_reg <= hwdata;
            if (wv_reg && wa_reg == OFS_SLOT_CTL) ctl_reg <= hwdata;
            if (wv_reg && wa_reg == OFS_PM_CTL) pm_reg <= hwdata;
            ilk_reg <= interlock_out ? ilk_reg + 1 : 0;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Toggle mode may hold the level indefinitely, so only timed pulses are measured
    sequence ilk_drop_s;
        $fell(interlock_out) && !cfg_reg[CFG_TOGGLE];
    endsequence
    ilk_width_a: assert property (ilk_drop_s |-> ilk_reg == ILK_CYCLES)
        else $error("interlock pulse length wrong");
    cap_gate_a: assert property (!$past(cap_reg[CAP_HPC]) |->
                                 !slot_power_enable_out && !interlock_out && !attention_indicator_out)
        else $error("slot output active while not capable");
    irq_gate_a: assert property (msi_req || intx_assert |-> ctl_reg[CTL_IRQ_ON])
        else $error("interrupt while interrupts disabled");
    irq_route_a: assert property (msi_req |-> !intx_assert)
        else $error("msi and intx together");
    ge_block_a: assert property (msi_req || pme_msg_req |-> !$past(pm_reg[PM_GE_CTL]))
        else $error("msi or wake in general event mode");
    ge_status_a: assert property ($rose(general_event_out) |-> $past(pm_reg[PM_GE_CTL]))
        else $error("general event outside its mode");
    gpio_alt_a: assert property (gpio7_out |-> general_event_out && $past(pm_reg[PM_GPIO_ALT]))
        else $error("gpio shows event without alternate function");
    pme_pulse_a: assert property (pme_msg_req |=> !pme_msg_req)
        else $error("wake request longer than one cycle");
endmodule : slot_hotplug_asserts

bind downstream_slot_hotplug_ctrl slot_hotplug_asserts #(.ILK_CYCLES(ILK_CYCLES)) asserts_i (
    .clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .attention_indicator_out,
    .slot_power_enable_out, .interlock_out, .intx_assert, .msi_req, .pme_msg_req, .general_event_out, .gpio7_out);

// ---- testbench/slot_expander_model.sv ----
`timescale 1ns/10ps
module slot_expander_model (
    input  wire logic       clk,
    input  wire logic [4:0] pol,
    input  wire logic [3:0] lvl,
    input  wire logic       slot_power_enable_out,
    output logic            attention_button_in,
    output logic            power_fault_in,
    output logic            retention_latch_in,
    output logic            presence_detect_in,
    output logic            slot_power_good_in
);
    // Power good lags the enable by one cycle, like a slow supply
    logic pgood_reg = 1'b0;
    always_ff @(posedge clk) pgood_reg <= slot_power_enable_out;
    assign attention_button_in = lvl[0] ^ pol[0];
    assign power_fault_in      = lvl[1] ^ pol[1];
    assign retention_latch_in  = lvl[2] ^ pol[2];
    assign presence_detect_in  = lvl[3] ^ pol[3];
    assign slot_power_good_in  = pgood_reg ^ pol[4];
endmodule : slot_expander_model

// ---- testbench/downstream_slot_hotplug_ctrl_tb.sv ----
`timescale 1ns/10ps
module downstream_slot_hotplug_ctrl_tb
    import slot_hotplug_pkg::*;
;
    localparam int ILK_T = 20;
    logic        clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'b00;
    logic [4:0]  pol = 5'h00;
    logic [3:0]  lvl = 4'h0;
    logic        hreadyout, attention_button_in, presence_detect_in, power_fault_in, retention_latch_in;
    logic        slot_power_good_in, attention_indicator_out, power_indicator_out, slot_power_enable_out;
    logic        interlock_out, intx_assert, msi_req, pme_msg_req, general_event_out, gpio7_out;
    int          compares = 0, miscompares = 0, n_msi = 0, n_pme = 0, ilk_len = 0, m0, p0, k;

    always #4 clk = ~clk;
    always @(posedge clk) begin
        n_msi   += msi_req;
        n_pme   += pme_msg_req;
        ilk_len += interlock_out;
    end

    downstream_slot_hotplug_ctrl #(.ILK_CYCLES(ILK_T), .MS_CYCLES(10)) dut (
        .clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata,
        .hreadyout, .hrdata, .hresp(), .attention_button_in, .presence_detect_in, .power_fault_in,
        .retention_latch_in, .slot_power_good_in, .attention_indicator_out, .power_indicator_out,
        .slot_power_enable_out, .interlock_out, .intx_assert, .msi_req, .pme_msg_req, .general_event_out, .gpio7_out);
    slot_expander_model expander (.clk, .pol, .lvl, .slot_power_enable_out, .attention_button_in,
        .power_fault_in, .retention_latch_in, .presence_detect_in, .slot_power_good_in);

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(n, q & m, e);
    endtask : rdc
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    task automatic end_of_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_of_test;
    end
    initial begin
        void'($urandom(15987));
        pol = 5'($urandom());
        idle(8);
        arst_n <= 1'b1;
        idle(4);
        rdc(OFS_SLOT_CTL, 32'hFFFF_FFFF, 32'h0000_011F, "ctl_reset");
        rdc(OFS_SLOT_STS, 32'h1F, 32'h0, "flags_reset");
        rdc(8'h18, 32'hFFFF_FFFF, 32'h0, "unmapped");
        // Polarity goes in before capable, else the polarity change itself fakes an edge
        wr(OFS_HP_CFG, {27'h0, pol});
        wr(OFS_SLOT_CAP, 32'h3);
        wr(OFS_SLOT_CTL, 32'h20);
        idle(4);
        chk("intx_level", intx_assert, 32'h1);
        wr(OFS_PM_CTL, 32'h1);
        idle(3);
        chk("intx_msi_mode", intx_assert, 32'h0);
        wr(OFS_SLOT_STS, 32'h1F);
        m0 = n_msi;
        for (int i = 0; i < 4; i++) begin
            lvl[i] <= 1'b1;
            idle(8);
            rdc(OFS_SLOT_STS, 32'h1F, 32'h1 << i, "event_flag");
            wr(OFS_SLOT_STS, 32'h1 << i);
        end
        chk("event_msi", n_msi - m0, 32'h4);
        rdc(OFS_SLOT_STS, 32'h160, 32'h160, "slot_state");
        chk("power_on", slot_power_enable_out, 32'h1);
        wr(OFS_HP_CFG, {27'h0, pol} | 32'h800);
        idle(3);
        chk("auto_power_off", slot_power_enable_out, 32'h0);
        wr(OFS_HP_CFG, {27'h0, pol} | 32'h400);
        rdc(OFS_SLOT_STS, 32'hA0, 32'h80, "latch_as_ilk");
        wr(OFS_HP_CFG, {27'h0, pol});
        m0 = n_msi;
        k = ilk_len;
        wr(OFS_SLOT_CTL, 32'h220);
        idle(30);
        chk("ilk_pulse", ilk_len - k, ILK_T);
        wr(OFS_HP_CFG, {27'h0, pol} | 32'h200);
        wr(OFS_SLOT_CTL, 32'h220);
        idle(3);
        rdc(OFS_SLOT_STS, 32'h80, 32'h80, "ilk_state");
        wr(OFS_SLOT_CTL, 32'h220);
        idle(3);
        chk("ilk_toggle", interlock_out, 32'h0);
        chk("cc_msi", n_msi - m0, 32'h3);
        // Wake cases with resend off so that counts stay exact
        wr(OFS_PM_CTL, 32'h5);
        m0 = n_msi;
        p0 = n_pme;
        wr(OFS_SLOT_CTL, 32'h20);
        idle(4);
        chk("cc_no_wake", n_pme - p0, 32'h0);
        lvl[3] <= 1'b0;
        idle(8);
        chk("wake_and_irq", n_pme - p0 + n_msi - m0, 32'h3);
        wr(OFS_SLOT_CTL, 32'h10);
        lvl[3] <= 1'b1;
        idle(8);
        chk("wake_no_irq", n_pme - p0, 32'h2);
        chk("irq_off", n_msi - m0, 32'h2);
        wr(OFS_SLOT_CTL, 32'h18);
        lvl[3] <= 1'b0;
        idle(8);
        chk("masked_event", n_pme - p0 + n_msi - m0, 32'h4);
        wr(OFS_PM_CTL, 32'h0002_0005);
        p0 = n_pme;
        idle(60);
        chk("wake_resend", 32'(n_pme - p0 != 0), 32'h1);
        wr(OFS_PM_CTL, 32'h0002_0105);
        idle(2);
        p0 = n_pme;
        idle(60);
        chk("resend_stop", n_pme - p0, 32'h0);
        wr(OFS_SLOT_STS, 32'h1F);
        wr(OFS_PM_CTL, 32'h11);
        m0 = n_msi;
        wr(OFS_SLOT_CTL, 32'hE0);
        lvl[3] <= 1'b1;
        idle(8);
        chk("ge_out", general_event_out, 32'h1);
        chk("attn_ind", attention_indicator_out, 32'h1);
        chk("power_ind", power_indicator_out, 32'h1);
        chk("ge_no_msi", n_msi - m0, 32'h0);
        chk("ge_gpio_off", gpio7_out, 32'h0);
        rdc(OFS_GE_STS, 32'h1, 32'h1, "ge_status");
        rdc(OFS_SLOT_STS, 32'h8, 32'h8, "ge_flag");
        wr(OFS_PM_CTL, 32'h31);
        idle(3);
        chk("ge_gpio_alt", gpio7_out, 32'h1);
        end_of_test;
    end
endmodule : downstream_slot_hotplug_ctrl_tb
